// File: src/esw_core.sv
// The implementer's own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module esw_core #(
  parameter int AGE_TICK = esw_pkg::AGE_TICK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Static straps
  input wire logic pause_en,
  input wire logic backpressure_en,
  input wire logic cut_through,
  input wire logic storm_en,
  // Per-port status
  input wire logic [esw_pkg::NPORT-1:0] link_up,
  input wire logic [esw_pkg::NPORT-1:0] full_duplex,
  input wire logic [esw_pkg::NPORT-1:0] congested,
  input wire logic [esw_pkg::NPORT-1:0] pause_rx,
  // Nonvolatile identifier load
  input wire logic switch_identifier_valid,
  input wire logic [47:0] switch_identifier_in,
  // Received frame header (one pulse per frame event)
  input wire logic rx_start,
  input wire logic [esw_pkg::PW-1:0] rx_port,
  input wire logic [47:0] rx_da,
  input wire logic [47:0] rx_sa,
  input wire logic [15:0] rx_type,
  input wire logic rx_byte,
  input wire logic rx_end,
  input wire logic rx_crc_ok,
  // Forwarding decision
  output logic fwd_go,
  output logic [esw_pkg::NPORT-1:0] fwd_ports,
  output logic [2:0] fwd_pages,
  output logic [esw_pkg::PAGE_AW-1:0] fwd_page,
  output logic fwd_drop,
  // Flow control and probe
  output logic [esw_pkg::NPORT-1:0] pause_tx,
  output logic [esw_pkg::NPORT-1:0] backpressure,
  output logic [esw_pkg::NPORT-1:0] tx_hold,
  output logic probe_req,
  output logic [47:0] probe_sa,
  output logic [15:0] probe_type,
  output logic loop_detected_indicator
);
  import esw_pkg::*;

  // ------------------------------------------------------------
  // Hash and helpers
  // ------------------------------------------------------------
  function automatic logic [TBL_AW-1:0] addr_hash(input logic [47:0] a);
    addr_hash = a[12:0] ^ a[25:13] ^ a[38:26] ^ {4'h0, a[47:39]};
  endfunction

  logic [31:0] ctrl;
  logic [47:0] swid;
  logic [15:0] drops;
  logic [15:0] learned;
  logic [31:0] tick_cnt;
  logic tick;
  logic [15:0] sweep_cnt;
  logic sweep;
  logic [1:0] epoch;
  logic [10:0] rx_len;
  logic rx_active;
  logic [PW-1:0] cur_port;
  logic [47:0] cur_da;
  logic [47:0] cur_sa;
  logic cur_probe;
  logic [NPORT-1:0] cur_dst;
  logic [NPORT-1:0] dst_mask;
  logic lk_valid;
  logic cut_sent;
  logic [PAGE_AW-1:0] free_ptr;

  // ------------------------------------------------------------
  // Timebase: 100 ms tick, ageing sweep, probe period
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 32'(AGE_TICK - 1));
      tick_cnt <= (tick_cnt == 32'(AGE_TICK - 1)) ? 32'h0 : tick_cnt + 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sweep_cnt <= 16'h0;
      sweep <= 1'b0;
      epoch <= 2'h0;
    end else begin
      sweep <= 1'b0;
      if (tick) begin
        if (sweep_cnt == 16'(AGE_SWEEP_TICKS - 1)) begin
          sweep_cnt <= 16'h0;
          sweep <= 1'b1;
          epoch <= epoch + 2'h1;
        end else begin
          sweep_cnt <= sweep_cnt + 16'h1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Address table: hashed main memory plus overflow store
  // ------------------------------------------------------------
  // Entry: valid, epoch stamp, port, address
  logic tbl_we;
  logic [TBL_AW-1:0] tbl_addr;
  logic [52:0] tbl_wdata;
  logic [52:0] tbl_rdata;
  logic [CAM_ENTRIES-1:0] cam_v;
  logic [47:0] cam_mac [CAM_ENTRIES];
  logic [PW-1:0] cam_port [CAM_ENTRIES];
  logic [1:0] cam_ep [CAM_ENTRIES];
  logic [CAM_AW-1:0] cam_wr;
  logic [CAM_ENTRIES-1:0] cam_hit_sa;
  logic [CAM_ENTRIES-1:0] cam_hit_da;
  logic [PW-1:0] cam_da_port;

  esw_mem #(.AW(TBL_AW), .DW(53)) u_tbl (
    .clk(clk),
    .we(tbl_we),
    .addr(tbl_addr),
    .wdata(tbl_wdata),
    .rdata(tbl_rdata)
  );

  // Aged: stamp two or more epochs behind the current one
  function automatic logic is_stale(input logic [1:0] ep, input logic [1:0] now);
    is_stale = (2'(now - ep) >= 2'd2);
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < CAM_ENTRIES; gi++) begin : g_cam
      assign cam_hit_sa[gi] = cam_v[gi] && (cam_mac[gi] == cur_sa);
      assign cam_hit_da[gi] = cam_v[gi] && (cam_mac[gi] == cur_da);
    end
  endgenerate

  always_comb begin
    cam_da_port = '0;
    for (int i = 0; i < CAM_ENTRIES; i++) begin
      if (cam_hit_da[i]) begin
        cam_da_port = cam_port[i];
      end
    end
  end

  // Lookup sequence: DA read at header, SA write after header
  typedef enum logic [1:0] {ESW_LK_IDLE, ESW_LK_DA, ESW_LK_SA} esw_lk_t;
  esw_lk_t lk_st;
  logic [NPORT-1:0] all_but_src;

  assign all_but_src = ~(NPORT'(1) << cur_port);

  always_comb begin
    tbl_we = 1'b0;
    tbl_addr = addr_hash(rx_start ? rx_da : cur_sa);
    tbl_wdata = {1'b1, epoch, cur_port, cur_sa};
    if (lk_st == ESW_LK_SA) begin
      tbl_addr = addr_hash(cur_sa);
      tbl_we = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lk_st <= ESW_LK_IDLE;
      dst_mask <= '0;
      lk_valid <= 1'b0;
      cam_v <= '0;
      cam_wr <= '0;
      learned <= 16'h0;
    end else begin
      if (sweep) begin
        for (int i = 0; i < CAM_ENTRIES; i++) begin
          if (is_stale(cam_ep[i], epoch)) begin
            cam_v[i] <= 1'b0;
          end
        end
      end
      case (lk_st)
        ESW_LK_IDLE: begin
          if (rx_start) begin
            lk_st <= ESW_LK_DA;
            lk_valid <= 1'b0;
          end
        end
        ESW_LK_DA: begin
          if (cur_da[40]) begin
            dst_mask <= all_but_src;
          end else if (|cam_hit_da) begin
            dst_mask <= NPORT'(1) << cam_da_port;
          end else if (tbl_rdata[52] && tbl_rdata[47:0] == cur_da
                       && !is_stale(tbl_rdata[51:50], epoch)) begin
            dst_mask <= NPORT'(1) << tbl_rdata[48 +: PW];
          end else begin
            dst_mask <= all_but_src;
          end
          lk_valid <= 1'b1;
          lk_st <= ESW_LK_SA;
        end
        ESW_LK_SA: begin
          // Hash slot always overwritten; unicast non-probe sources also go to the overflow store
          lk_st <= ESW_LK_IDLE;
          if (!cur_sa[40] && !cur_probe) begin
            if (|cam_hit_sa) begin
              for (int i = 0; i < CAM_ENTRIES; i++) begin
                if (cam_hit_sa[i]) begin
                  cam_port[i] <= cur_port;
                  cam_ep[i] <= epoch;
                end
              end
            end else begin
              learned <= learned + 16'h1;
              cam_v[cam_wr] <= 1'b1;
              cam_mac[cam_wr] <= cur_sa;
              cam_port[cam_wr] <= cur_port;
              cam_ep[cam_wr] <= epoch;
              cam_wr <= cam_wr + CAM_AW'(1);
            end
          end
        end
        default: lk_st <= ESW_LK_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Reception, filtering and forwarding
  // ------------------------------------------------------------
  always_comb begin
    cur_dst = dst_mask;
    for (int p = 0; p < NPORT; p++) begin
      if (!link_up[p]) begin
        cur_dst[p] = 1'b0;
      end
    end
  end

  logic flow_ctl;
  assign flow_ctl = pause_en || backpressure_en;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_active <= 1'b0;
      rx_len <= 11'h0;
      cur_port <= '0;
      cur_da <= 48'h0;
      cur_sa <= 48'h0;
      cur_probe <= 1'b0;
      cut_sent <= 1'b0;
      fwd_go <= 1'b0;
      fwd_drop <= 1'b0;
      fwd_ports <= '0;
      fwd_pages <= 3'h0;
      fwd_page <= '0;
      free_ptr <= '0;
      drops <= 16'h0;
    end else begin
      fwd_go <= 1'b0;
      fwd_drop <= 1'b0;
      if (rx_start) begin
        rx_active <= 1'b1;
        rx_len <= 11'h0;
        cur_port <= rx_port;
        cur_da <= rx_da;
        cur_sa <= rx_sa;
        cur_probe <= (rx_sa == swid) && (rx_type == PROBE_TYPE);
        cut_sent <= 1'b0;
      end else if (rx_active) begin
        if (rx_byte && rx_len != 11'h7ff) begin
          rx_len <= rx_len + 11'h1;
        end
        if (cut_through && !cut_sent && lk_valid && rx_len >= CUT_LEN) begin
          cut_sent <= 1'b1;
          if (!flow_ctl && |(cur_dst & congested)) begin
            fwd_drop <= 1'b1;
            drops <= drops + 16'h1;
          end else begin
            fwd_go <= 1'b1;
            fwd_ports <= cur_dst;
            fwd_page <= free_ptr;
            fwd_pages <= 3'(MAX_PAGES);
            free_ptr <= free_ptr + PAGE_AW'(MAX_PAGES);
          end
        end
        if (rx_end) begin
          rx_active <= 1'b0;
          if (rx_len < RUNT_LEN || !rx_crc_ok || cur_probe
              || (!cut_through && rx_len > MAX_LEN)) begin
            if (!cut_sent) begin
              fwd_drop <= 1'b1;
              drops <= drops + 16'h1;
            end
          end else if (!cut_sent) begin
            if (!flow_ctl && |(cur_dst & congested)) begin
              fwd_drop <= 1'b1;
              drops <= drops + 16'h1;
            end else begin
              // Whole frame in: store-and-forward or short cut-through frame
              fwd_go <= 1'b1;
              fwd_ports <= cur_dst;
              fwd_page <= free_ptr;
              // One page per 256 bytes, clamped to seven
              fwd_pages <= (rx_len[10:8] >= 3'(MAX_PAGES)) ? 3'(MAX_PAGES)
                           : rx_len[10:8] + 3'h1;
              free_ptr <= free_ptr + PAGE_AW'((rx_len[10:8] >= 3'(MAX_PAGES))
                          ? 3'(MAX_PAGES) : rx_len[10:8] + 3'h1);
            end
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Flow control per port
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pause_tx <= '0;
      backpressure <= '0;
      tx_hold <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        pause_tx[p] <= pause_en && full_duplex[p] && congested[p];
        backpressure[p] <= backpressure_en && !full_duplex[p] && congested[p];
        tx_hold[p] <= pause_en && full_duplex[p] && pause_rx[p];
      end
    end
  end

  // ------------------------------------------------------------
  // Loop probe and indicator
  // ------------------------------------------------------------
  logic [7:0] probe_cnt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      swid <= 48'h0;
      probe_cnt <= 8'h0;
      probe_req <= 1'b0;
      probe_sa <= 48'h0;
      probe_type <= 16'h0;
    end else begin
      probe_req <= 1'b0;
      if (switch_identifier_valid) begin
        swid <= switch_identifier_in;
      end
      if (tick) begin
        if (probe_cnt == 8'(PROBE_TICKS - 1)) begin
          probe_cnt <= 8'h0;
          // Probe goes to all ports with BCAST DA, zero payload, PROBE_LEN bytes
          probe_req <= ctrl[CTRL_PROBE_EN];
          probe_sa <= swid;
          probe_type <= PROBE_TYPE;
        end else begin
          probe_cnt <= probe_cnt + 8'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_detected_indicator <= 1'b0;
    end else if (rx_end && rx_active && cur_probe && cur_da == BCAST) begin
      loop_detected_indicator <= 1'b1;
    end else if (link_up == '0) begin
      loop_detected_indicator <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0;
        case (paddr)
          A_CTRL: prdata <= ctrl;
          A_STATUS: prdata <= {16'h0, full_duplex, link_up, 3'h0, storm_en,
                               cut_through, backpressure_en, pause_en,
                               loop_detected_indicator};
          A_SWID_LO: prdata <= swid[31:0];
          A_SWID_HI: prdata <= {16'h0, swid[47:32]};
          A_DROPS: prdata <= {16'h0, drops};
          A_LEARNED: prdata <= {16'h0, learned};
          default: pslverr <= 1'b1;
        endcase
      end
      // Write lands only at the edge where the master samples pready
      if (psel && penable && pready && pwrite && paddr == A_CTRL) begin
        ctrl <= pwdata;
      end
    end
  end
endmodule

// File: src/esw_pkg.sv
// Notes on behaviour
// - Keep learned addresses in 8K hashed table plus 128-entry overflow store.
// - Table location for an address is chosen by hashing the address.
// - Entries unseen for one ageing interval (215 to 322 s) are removed; code drops overflow entries after 107.6 to 215.2 s, ignores hashed ones 2-3 epochs old.
// - Frames under 64 bytes are always discarded, never forwarded.
// - In store-and-forward mode frames over 1536 bytes are discarded.
// - Frame memory is 1K pages of 256 bytes each.
// - Each buffered frame takes at least one and at most seven pages.
// - Store-and-forward: no transmission before the whole frame is received.
// - Cut-through: forwarding starts once 512 bytes have arrived.
// - Cut-through: frames under 512 bytes forward when reception completes.
// - Flow control is chosen per port from that port's duplex setting.
// - Full-duplex port with flow control honours PAUSE both ways.
// - Half-duplex port with flow control applies backpressure on the segment.
// - Without flow control, frames to a congested port are dropped.
// - Switch identifier is read from nonvolatile storage and sources loop probes.
// - Loop probe: 64 bytes, all-ones destination, identifier, 0040, zeros, CRC.
// - Receiving our own loop probe asserts the loop-detected indicator.
// - Static inputs select PAUSE, backpressure, cut-through and storm control; storm_en is only read back in the status register.
package esw_pkg;
  localparam int NPORT = 4;
  localparam int PW = 2;
  localparam int TBL_ENTRIES = 8192;
  localparam int TBL_AW = 13;
  localparam int CAM_ENTRIES = 128;
  localparam int CAM_AW = 7;
  localparam int PAGES = 1024;
  localparam int PAGE_AW = 10;
  localparam int PAGE_BYTES = 256;
  localparam int MAX_PAGES = 7;
  localparam logic [10:0] RUNT_LEN = 11'd64;
  localparam logic [10:0] MAX_LEN = 11'd1536;
  localparam logic [10:0] CUT_LEN = 11'd512;
  localparam logic [10:0] PROBE_LEN = 11'd64;
  localparam logic [15:0] PROBE_TYPE = 16'h0040;
  localparam logic [47:0] BCAST = 48'hffffffffffff;
  localparam int CLK_MHZ = 100;
  localparam int AGE_TICK_MS = 100;
  localparam int AGE_TICK_CYC = AGE_TICK_MS * 1000 * CLK_MHZ;
  localparam int AGE_MIN_S = 215;
  // Two-step age stamps: entry dies at the second sweep after its stamp, 1..2 periods of AGE_SWEEP_TICKS
  localparam int AGE_SWEEP_TICKS = (AGE_MIN_S * 1000) / (2 * AGE_TICK_MS) + 1;
  localparam int PROBE_MS = 1000;
  localparam int PROBE_TICKS = PROBE_MS / AGE_TICK_MS;
  // APB map
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_SWID_LO = 8'h08;
  localparam logic [7:0] A_SWID_HI = 8'h0c;
  localparam logic [7:0] A_DROPS = 8'h10;
  localparam logic [7:0] A_LEARNED = 8'h14;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_PROBE_EN = 0;
  typedef enum logic [1:0] {ESW_FWD_NONE, ESW_FWD_UNI, ESW_FWD_FLOOD} esw_fwd_t;
endpackage

// File: src/esw_mem.sv
`timescale 1ns/1ns
// Single-port table memory, registered read data
module esw_mem #(
  parameter int AW = 13,
  parameter int DW = 52
) (
  // Clock
  input wire logic clk,
  // Access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// File: bench/esw_chk_assertions.sv
`timescale 1ns/1ns
module esw_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Straps and port levels
  input wire logic cut_through,
  input wire logic pause_en,
  input wire logic backpressure_en,
  input wire logic [esw_pkg::NPORT-1:0] link_up,
  input wire logic [esw_pkg::NPORT-1:0] full_duplex,
  // Frame events
  input wire logic rx_start,
  input wire logic rx_byte,
  input wire logic rx_end,
  // Decisions and indicators
  input wire logic fwd_go,
  input wire logic fwd_drop,
  input wire logic [2:0] fwd_pages,
  input wire logic [esw_pkg::NPORT-1:0] pause_tx,
  input wire logic [esw_pkg::NPORT-1:0] backpressure,
  input wire logic probe_req,
  input wire logic [15:0] probe_type,
  input wire logic loop_detected_indicator
);
  import esw_pkg::*;
  // Bytes seen since the frame began
  logic [10:0] nbytes;
  always_ff @(posedge clk) begin
    if (!rst_n || rx_start) begin
      nbytes <= 11'h000;
    end else if (rx_byte) begin
      nbytes <= nbytes + 11'h001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_saf_waits: assert property (fwd_go && !cut_through |-> $past(rx_end))
    else $error("forward before frame end");
  chk_end_answer: assert property (rx_end && (!cut_through || nbytes < CUT_LEN)
    |=> fwd_go || fwd_drop)
    else $error("no decision after frame end");
  chk_cut_start: assert property (rx_byte && cut_through && nbytes == CUT_LEN - 11'h001
    |-> ##2 fwd_go || fwd_drop)
    else $error("cut-through did not start");
  chk_runt_drop: assert property (rx_end && nbytes < RUNT_LEN |=> fwd_drop && !fwd_go)
    else $error("short frame not dropped");
  chk_long_drop: assert property (rx_end && !cut_through && nbytes > MAX_LEN
    |=> fwd_drop && !fwd_go)
    else $error("long frame not dropped");
  chk_page_count: assert property (fwd_go |-> fwd_pages != 3'h0
    && (!(cut_through && nbytes >= CUT_LEN) || fwd_pages == 3'h7))
    else $error("page count out of range");
  chk_probe_type: assert property (probe_req |-> probe_type == PROBE_TYPE)
    else $error("probe type field wrong");
  chk_loop_clear: assert property (link_up == '0 |=> !loop_detected_indicator)
    else $error("loop indicator kept without links");
  chk_pause_gate: assert property ((pause_tx
    & ~({NPORT{$past(pause_en)}} & $past(full_duplex))) == '0)
    else $error("pause on wrong port");
  chk_bp_gate: assert property ((backpressure
    & ~({NPORT{$past(backpressure_en)}} & ~$past(full_duplex))) == '0)
    else $error("backpressure on wrong port");
endmodule

// File: bench/esw_link_partner.sv
`timescale 1ns/1ns
module esw_link_partner (
  // Clock
  input wire logic clk,
  // Frame towards the core
  output logic rx_start,
  output logic [esw_pkg::PW-1:0] rx_port,
  output logic [47:0] rx_da,
  output logic [47:0] rx_sa,
  output logic [15:0] rx_type,
  output logic rx_byte,
  output logic rx_end,
  output logic rx_crc_ok
);
  import esw_pkg::*;
  initial begin
    {rx_start, rx_port, rx_da, rx_sa, rx_type, rx_byte, rx_end, rx_crc_ok} = '0;
  end
  // Gap stretches the byte rate to model a slow station
  task automatic send(input logic [1:0] p, input logic [47:0] da, input logic [47:0] sa,
                      input logic [15:0] ty, input int len, input int gap, input logic crc);
    @(posedge clk);
    rx_start <= 1'b1;
    rx_port <= p;
    rx_da <= da;
    rx_sa <= sa;
    rx_type <= ty;
    for (int i = 0; i < len; i++) begin
      @(posedge clk);
      rx_start <= 1'b0;
      rx_byte <= 1'b1;
      repeat (gap) begin
        @(posedge clk);
        rx_byte <= 1'b0;
      end
    end
    @(posedge clk);
    rx_byte <= 1'b0;
    rx_end <= 1'b1;
    rx_crc_ok <= crc;
    @(posedge clk);
    // Stale header fields are inverted so nothing leans on old values
    rx_end <= 1'b0;
    rx_crc_ok <= ~crc;
    rx_port <= ~p;
    rx_da <= ~da;
    rx_sa <= ~sa;
    rx_type <= ~ty;
  endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import esw_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pause_en, backpressure_en, cut_through, storm_en, e;
  logic [NPORT-1:0] link_up, full_duplex, congested, pause_rx, fwd_ports, pause_tx;
  logic [NPORT-1:0] backpressure, tx_hold;
  logic switch_identifier_valid, rx_start, rx_byte, rx_end, rx_crc_ok;
  logic [47:0] switch_identifier_in, rx_da, rx_sa, probe_sa, swid, stn;
  logic [PW-1:0] rx_port;
  logic [15:0] rx_type, probe_type;
  logic fwd_go, fwd_drop, probe_req, loop_detected_indicator, got_go, got_drop;
  logic [2:0] fwd_pages, got_pages;
  logic [PAGE_AW-1:0] fwd_page;
  int num_errors, checks, seed, n;
  int lens[4] = '{63, 64, 1536, 1537};
  int ctl[4] = '{100, 511, 600, 1000};
  esw_core #(.AGE_TICK(10)) dut (.*);
  esw_link_partner lp (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (fwd_go) begin
      got_go <= 1'b1;
      got_pages <= fwd_pages;
    end
    if (fwd_drop) got_drop <= 1'b1;
  end
  task check(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks++;
    if (exp !== got) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", 48'h1, 48'(pready));
  endtask
  function automatic logic [2:0] exp_pages(input int len, input logic ct);
    if ((ct && len >= int'(CUT_LEN)) || len / 256 + 1 > 7) return 3'h7;
    return 3'(len / 256 + 1);
  endfunction
  task frame(input logic [1:0] p, input logic [47:0] da, input logic [47:0] sa,
             input int len, input logic go);
    got_go <= 1'b0;
    got_drop <= 1'b0;
    lp.send(p, da, sa, 16'h0800, len, $unsigned($random(seed)) % 2, 1'b1);
    repeat (3) @(posedge clk);
    check("fwd_go", 48'(go), 48'(got_go));
    check("fwd_drop", 48'(!go), 48'(got_drop));
    if (go) check("fwd_pages", 48'(exp_pages(len, cut_through)), 48'(got_pages));
  endtask
  task final_report;
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    final_report;
  end
  initial begin
    seed = 32'he3f8;
    {clk, rst_n, psel, penable, pwrite, paddr, pwdata, storm_en, congested} = '0;
    {switch_identifier_valid, switch_identifier_in, cut_through, got_go, got_drop} = '0;
    {pause_en, backpressure_en, link_up, full_duplex, pause_rx} = {2'b11, 4'hf, 4'hf, 4'h0};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    swid = 48'({$random(seed), $random(seed)});
    switch_identifier_valid <= 1'b1;
    switch_identifier_in <= swid;
    @(posedge clk);
    switch_identifier_valid <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0);
    check("ctrl reset", 48'(CTRL_RST), 48'(r));
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", 48'h1, 48'(e));
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b0, A_CTRL, 32'h0);
    check("ctrl written", 48'h0, 48'(r));
    apb(1'b1, A_CTRL, CTRL_RST);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (probe_req !== 1'b1 && n < 3000);
    check("probe source", swid, probe_sa);
    check("probe type", 48'(PROBE_TYPE), 48'(probe_type));
    foreach (lens[i]) frame(2'(i), BCAST, 48'($random(seed)), lens[i], i % 3 != 0);
    repeat (6) frame(2'($random(seed)), 48'($random(seed)), 48'($random(seed)),
                     64 + $unsigned($random(seed)) % 700, 1'b1);
    cut_through <= 1'b1;
    foreach (ctl[i]) frame(2'(i), BCAST, 48'($random(seed)), ctl[i], 1'b1);
    frame(2'h1, BCAST, 48'h1, 63, 1'b0);
    cut_through <= 1'b0;
    pause_en <= 1'b0;
    backpressure_en <= 1'b0;
    stn = 48'h0000_1234_5678;
    frame(2'h1, BCAST, stn, 64, 1'b1);
    congested <= 4'h2;
    frame(2'h0, stn, 48'h9, 64, 1'b0);
    pause_en <= 1'b1;
    backpressure_en <= 1'b1;
    full_duplex <= 4'h5;
    pause_rx <= 4'($random(seed));
    congested <= 4'hf;
    repeat (20) @(posedge clk);
    check("pause ports", 48'h0, 48'(pause_tx & ~full_duplex));
    check("backpressure ports", 48'h0, 48'(backpressure & full_duplex));
    check("tx hold", 48'(pause_rx & 4'h5), 48'(tx_hold));
    congested <= 4'h0;
    lp.send(2'h2, BCAST, swid, PROBE_TYPE, 64, 0, 1'b1);
    repeat (3) @(posedge clk);
    check("loop set", 48'h1, 48'(loop_detected_indicator));
    link_up <= 4'h0;
    repeat (3) @(posedge clk);
    check("loop clear", 48'h0, 48'(loop_detected_indicator));
    link_up <= 4'hf;
    final_report;
  end
endmodule
bind esw_core esw_chk u_chk (.clk(clk), .rst_n(rst_n), .cut_through(cut_through),
  .pause_en(pause_en), .backpressure_en(backpressure_en), .link_up(link_up),
  .full_duplex(full_duplex), .rx_start(rx_start), .rx_byte(rx_byte), .rx_end(rx_end),
  .fwd_go(fwd_go), .fwd_drop(fwd_drop), .fwd_pages(fwd_pages), .pause_tx(pause_tx),
  .backpressure(backpressure), .probe_req(probe_req), .probe_type(probe_type),
  .loop_detected_indicator(loop_detected_indicator));
